// [hdl/wwdtc_top.sv]
// windowed watchdog control: register file, prescaler, window check, events
// Contract
// - period_select code n divides by 2^(n+5), up to code 10010.
// - period_select codes 10011 to 11111 give the shortest interval.
// - reset loads period_select with 01011 if period config is 11111, else config.
// - period_select writable only while period config is 11111.
// - software_enable obeyed only in operating mode 01, ignored otherwise.
// - clock_source_select 000..011 pick one of four clocks, 100..111 reserved.
// - clock config 111 resets clock_source_select to 000 and unlocks it.
// - opening_select resets from window config, read-only unless config is 111.
// - each opening code below 111 adds one eighth closed delay.
// - window closed while window_position is below four times (7 - opening_select).
// - 18-bit prescaler count split over low, high and timer registers.
// - timer and count registers are read-only and read zero after reset.
// - in windowed mode, clear while window closed or unarmed is a violation and resets.
// - any write to either control register clears the count.
// - operating mode 11 keeps the watchdog running, sleep included.
module wwdtc_top
  import wwdtc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [1:0] OPERATING_MODE_CONFIG,
  input wire logic [4:0] PERIOD_CONFIG,
  input wire logic [2:0] CLOCK_CONFIG,
  input wire logic [2:0] OPENING_CONFIG,
  input wire logic [NSRC-1:0] SRC_CLK_TICK,
  input wire logic SLEEP,
  input wire logic CLEAR_WATCHDOG,
  output logic WATCHDOG_RESET,
  output logic SLEEP_WAKE,
  output logic IRQ
);
  logic init_r, init_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [IDX_W-1:0] waddr_r, waddr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [4:0] period_select_r, period_select_nxt;
  logic software_enable_r, software_enable_nxt;
  logic [2:0] clock_source_select_r, clock_source_select_nxt;
  logic [2:0] opening_select_r, opening_select_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic armed_r, armed_nxt, sleep_r, sleep_nxt;
  logic [EV_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic rst_out_r, rst_out_nxt, wake_r, wake_nxt, irq_r, irq_nxt;
  logic [IDX_W-1:0] ridx;
  logic [4:0] p_eff, window_position, win_thr;
  logic [CNT_W:0] limit;
  logic wdt_on, tick, windowed, closed, do_wr, wr_clr, viol, tmo, good_clr;
  logic [NSRC-1:0] src_sel;

  assign ridx = S_AXI_ARADDR[IDX_W+1:2];
  // reserved period codes fall back to the shortest interval
  assign p_eff = (period_select_r > PS_MAX) ? PS_MIN : period_select_r;
  assign limit = ((CNT_W+1)'(1) << (p_eff + PS_BASE_SHIFT)) - (CNT_W+1)'(1);
  assign window_position = 5'(count_r >> p_eff);
  assign win_thr = 5'({2'h0, WIN_FULL - opening_select_r} << WIN_STEP_SH);
  assign windowed = opening_select_r != WIN_FULL;
  assign closed = windowed && (window_position < win_thr);

  // one strobe per clock source; reserved select codes give no edges at all
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    assign src_sel[g] = (clock_source_select_r == 3'(g)) && SRC_CLK_TICK[g];
  end

  always_comb begin
    case (OPERATING_MODE_CONFIG)
      MODE_ALWAYS: wdt_on = 1'b1;
      MODE_AWAKE: wdt_on = !SLEEP;
      MODE_SOFT: wdt_on = software_enable_r;
      default: wdt_on = 1'b0;
    endcase
  end

  assign tick = wdt_on && init_r && (|src_sel);
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;

  always_comb begin
    init_nxt = 1'b1;
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    period_select_nxt = period_select_r;
    software_enable_nxt = software_enable_r;
    clock_source_select_nxt = clock_source_select_r;
    opening_select_nxt = opening_select_r;
    count_nxt = count_r;
    armed_nxt = armed_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    wr_clr = 1'b0;
    // config straps are caught in the first cycle after reset release
    if (!init_r) begin
      period_select_nxt = (PERIOD_CONFIG == PS_UNLOCKED) ? PS_RESET : PERIOD_CONFIG;
      clock_source_select_nxt = (CLOCK_CONFIG == CS_UNLOCKED) ? CS_RESET : CLOCK_CONFIG;
      opening_select_nxt = OPENING_CONFIG;
    end
    if (S_AXI_AWVALID && awready_r) begin
      aw_hold_nxt = 1'b1;
      waddr_nxt = S_AXI_AWADDR[IDX_W+1:2];
    end
    if (S_AXI_WVALID && wready_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = S_AXI_WDATA[7:0];
      wstrb_nxt = S_AXI_WSTRB[0];
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (waddr_r)
        IDX_PERIOD_ENABLE: begin
          wr_clr = wstrb_r;
          if (wstrb_r && PERIOD_CONFIG == PS_UNLOCKED) begin
            period_select_nxt = wdata_r[B_PS+:5];
          end
          if (wstrb_r) begin
            software_enable_nxt = wdata_r[B_SEN];
          end
        end
        IDX_CLOCK_OPENING: begin
          wr_clr = wstrb_r;
          if (wstrb_r && CLOCK_CONFIG == CS_UNLOCKED) begin
            clock_source_select_nxt = wdata_r[B_CS+:3];
          end
          if (wstrb_r && OPENING_CONFIG == WIN_UNLOCKED) begin
            opening_select_nxt = wdata_r[B_WIN+:3];
          end
        end
        IDX_PSC_LOW, IDX_PSC_HIGH, IDX_TIMER_STATUS: begin
          // read-only: the write is acknowledged and dropped
          bresp_nxt = RESP_OKAY;
        end
        IDX_EVENT_STATUS: begin
          if (wstrb_r) begin
            stat_nxt = stat_r & ~wdata_r[EV_W-1:0];
          end
        end
        IDX_EVENT_MASK: begin
          if (wstrb_r) begin
            mask_nxt = wdata_r[EV_W-1:0];
          end
        end
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
    // arming and clear-instruction checks for windowed operation
    viol = CLEAR_WATCHDOG && wdt_on && windowed && (!armed_r || closed);
    good_clr = CLEAR_WATCHDOG && !viol;
    tmo = tick && ({1'b0, count_r} == limit);
    if (CLEAR_WATCHDOG) begin
      armed_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (ridx)
        IDX_PERIOD_ENABLE: begin
          rdata_nxt = {2'h0, period_select_r, software_enable_r};
          armed_nxt = 1'b1;
        end
        IDX_CLOCK_OPENING: rdata_nxt = {1'b0, clock_source_select_r, 1'b0, opening_select_r};
        IDX_PSC_LOW: rdata_nxt = count_r[7:0];
        IDX_PSC_HIGH: rdata_nxt = count_r[15:8];
        IDX_TIMER_STATUS: rdata_nxt = {window_position, armed_r, count_r[PSC_W-1:16]};
        IDX_EVENT_STATUS: rdata_nxt = 8'(stat_r);
        IDX_EVENT_MASK: rdata_nxt = 8'(mask_r);
        default: begin
          rdata_nxt = 8'h00;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    sleep_nxt = SLEEP;
    // entering or leaving sleep, a disable, a write or a good clear restart the period
    if (!wdt_on || wr_clr || (SLEEP != sleep_r) || good_clr || viol || tmo) begin
      count_nxt = '0;
    end else if (tick) begin
      count_nxt = count_r + CNT_W'(1);
    end
    // a new event wins over a clear in the same cycle
    stat_nxt[EV_TIMEOUT] = stat_nxt[EV_TIMEOUT] | tmo;
    stat_nxt[EV_VIOLATION] = stat_nxt[EV_VIOLATION] | viol;
    // a time-out asleep wakes the core instead of resetting it
    rst_out_nxt = (tmo || viol) && !SLEEP;
    wake_nxt = (tmo || viol) && SLEEP;
    irq_nxt = |(stat_nxt & mask_nxt);
    awready_nxt = !aw_hold_nxt;
    wready_nxt = !w_hold_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      init_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 8'h00;
      period_select_r <= PS_RESET;
      software_enable_r <= 1'b0;
      clock_source_select_r <= CS_RESET;
      opening_select_r <= WIN_FULL;
      count_r <= '0;
      armed_r <= 1'b0;
      sleep_r <= 1'b0;
      stat_r <= '0;
      mask_r <= '0;
      rst_out_r <= 1'b0;
      wake_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      init_r <= init_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      period_select_r <= period_select_nxt;
      software_enable_r <= software_enable_nxt;
      clock_source_select_r <= clock_source_select_nxt;
      opening_select_r <= opening_select_nxt;
      count_r <= count_nxt;
      armed_r <= armed_nxt;
      sleep_r <= sleep_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rst_out_r <= rst_out_nxt;
      wake_r <= wake_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RRESP = rresp_r;
  assign S_AXI_RDATA = {24'h000000, rdata_r};
  assign WATCHDOG_RESET = rst_out_r;
  assign SLEEP_WAKE = wake_r;
  assign IRQ = irq_r;

  AST_RESERVED_MIN: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (period_select_r > PS_MAX) |-> (limit == (CNT_W+1)'(31)))
    else $error("reserved period code not at shortest interval");
  AST_RESET_PERIOD: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (init_r && !$past(init_r) && $past(PERIOD_CONFIG) == PS_UNLOCKED) |-> (period_select_r == PS_RESET))
    else $error("period reset value wrong");
  AST_PERIOD_LOCK: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    ($past(init_r) && $past(PERIOD_CONFIG) != PS_UNLOCKED) |-> $stable(period_select_r))
    else $error("locked period select changed");
  AST_MODE_OFF: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (OPERATING_MODE_CONFIG == MODE_OFF) |=> (count_r == '0))
    else $error("count moved in off mode");
  AST_CLOCK_LOCK: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    ($past(init_r) && $past(CLOCK_CONFIG) != CS_UNLOCKED) |-> $stable(clock_source_select_r))
    else $error("locked clock select changed");
  AST_OPEN_LOCK: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    ($past(init_r) && $past(OPENING_CONFIG) != WIN_UNLOCKED) |-> $stable(opening_select_r))
    else $error("locked opening select changed");
  AST_FULL_OPEN: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (opening_select_r == WIN_FULL && CLEAR_WATCHDOG && !tick) |=> !(WATCHDOG_RESET || SLEEP_WAKE))
    else $error("clear in full-open mode raised a violation");
  AST_ARM_ON_READ: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (S_AXI_ARVALID && arready_r && ridx == IDX_PERIOD_ENABLE) |=> armed_r)
    else $error("read did not arm");
  AST_VIOLATION: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (CLEAR_WATCHDOG && wdt_on && windowed && !armed_r) |=> (WATCHDOG_RESET || SLEEP_WAKE) ##1 !WATCHDOG_RESET)
    else $error("unarmed clear gave no violation");
  AST_WRITE_CLEARS: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (do_wr && wstrb_r && (waddr_r == IDX_PERIOD_ENABLE || waddr_r == IDX_CLOCK_OPENING)) |=> (count_r == '0))
    else $error("control write did not clear count");
  AST_ALWAYS_ON: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (OPERATING_MODE_CONFIG == MODE_ALWAYS && SLEEP == sleep_r && init_r && (|src_sel) && ({1'b0, count_r} != limit)
      && !CLEAR_WATCHDOG && !wr_clr) |=> (count_r == $past(count_r) + CNT_W'(1)))
    else $error("always-on mode not running");
  AST_TIMEOUT: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (tick && {1'b0, count_r} == limit && !SLEEP && $stable(SLEEP)) |=> (WATCHDOG_RESET && count_r == '0))
    else $error("time-out not raised at ratio");
endmodule : wwdtc_top

// [hdl/wwdtc_pkg.sv]
// constants for the windowed watchdog control block
package wwdtc_pkg;
  localparam int unsigned IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_PERIOD_ENABLE = 10'h18c;
  localparam logic [IDX_W-1:0] IDX_CLOCK_OPENING = 10'h18d;
  localparam logic [IDX_W-1:0] IDX_PSC_LOW = 10'h18e;
  localparam logic [IDX_W-1:0] IDX_PSC_HIGH = 10'h18f;
  localparam logic [IDX_W-1:0] IDX_TIMER_STATUS = 10'h190;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 10'h191;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 10'h192;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [4:0] PS_UNLOCKED = 5'h1f;
  localparam logic [4:0] PS_RESET = 5'h0b;
  localparam logic [4:0] PS_MAX = 5'h12;
  localparam logic [4:0] PS_MIN = 5'h00;
  localparam logic [4:0] PS_BASE_SHIFT = 5'h05;
  localparam logic [2:0] CS_UNLOCKED = 3'h7;
  localparam logic [2:0] CS_RESET = 3'h0;
  localparam logic [2:0] WIN_UNLOCKED = 3'h7;
  localparam logic [2:0] WIN_FULL = 3'h7;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam int unsigned CNT_W = 23;
  localparam int unsigned PSC_W = 18;
  localparam int unsigned NSRC = 4;
  localparam int unsigned EV_TIMEOUT = 0;
  localparam int unsigned EV_VIOLATION = 1;
  localparam int unsigned EV_W = 2;
  localparam int unsigned B_SEN = 0;
  localparam int unsigned B_PS = 1;
  localparam int unsigned B_WIN = 0;
  localparam int unsigned B_CS = 4;
  localparam int unsigned B_ARMED = 2;
  localparam int unsigned B_WPOS = 3;
  localparam logic [1:0] WIN_STEP_SH = 2'h2;
endpackage : wwdtc_pkg

// [test/tb_top.sv]
// self-checking bench for the windowed watchdog control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wwdtc_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, wdr, wake, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [1:0] mode = '0;
  logic [4:0] pcfg = '0;
  logic [2:0] ccfg = '0, ocfg = '0;
  logic [NSRC-1:0] tck = '0;
  logic sleep = 0, clr = 0;
  int num_errors = 0, n_compared = 0, n_wdr = 0, n_wake = 0;
  int unsigned p, w, k, cs;
  always #12.5 clk = ~clk;
  wwdtc_top uut (.CORE_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .OPERATING_MODE_CONFIG(mode),
    .PERIOD_CONFIG(pcfg), .CLOCK_CONFIG(ccfg), .OPENING_CONFIG(ocfg), .SRC_CLK_TICK(tck), .SLEEP(sleep),
    .CLEAR_WATCHDOG(clr), .WATCHDOG_RESET(wdr), .SLEEP_WAKE(wake), .IRQ(irq));
  always @(posedge clk) begin
    if (wdr === 1'b1) n_wdr++;
    if (wake === 1'b1) n_wake++;
  end
  function automatic int unsigned ratio(input int unsigned ps);
    return (ps > 18) ? 32 : (32 << ps);
  endfunction : ratio
  function automatic int unsigned opens_at(input int unsigned win);
    return (win == 7) ? 0 : 4 * (7 - win);
  endfunction : opens_at
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task do_reset(input logic [1:0] m, input logic [4:0] pc, input logic [2:0] cc, input logic [2:0] oc);
    @(posedge clk);
    rstn <= 0;
    mode <= m;
    pcfg <= pc;
    ccfg <= cc;
    ocfg <= oc;
    sleep <= 0;
    repeat (20) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    n_wdr = 0;
    n_wake = 0;
  endtask : do_reset
  task wr(input logic [9:0] idx, input logic [7:0] v);
    int n;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) break;
    end
    bready <= 0;
    r = bresp;
    if (n == 50) chk(32'h0, 32'h1);
  endtask : wr
  task rd(input logic [9:0] idx);
    int n;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) break;
    end
    rready <= 0;
    d = rdata;
    r = rresp;
    if (n == 50) chk(32'h0, 32'h1);
  endtask : rd
  // one-cycle tick pulses on one source, then time for the output pulse to land
  task tick(input int unsigned src, input int unsigned n);
    repeat (n) begin
      @(posedge clk);
      tck <= NSRC'(1 << src);
      @(posedge clk);
      tck <= '0;
    end
    repeat (4) @(posedge clk);
  endtask : tick
  task clear_wd;
    @(posedge clk);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (4) @(posedge clk);
  endtask : clear_wd
  initial begin
    #(25 * 40000);
    num_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(43));
    do_reset(MODE_SOFT, PS_UNLOCKED, CS_UNLOCKED, WIN_UNLOCKED);
    // read-only registers first: a control read would arm and show in the timer register
    for (k = 0; k < 3; k++) begin
      rd(10'(IDX_PSC_LOW + k));
      chk(d, 32'h0);
    end
    rd(IDX_PERIOD_ENABLE);
    chk(d, {26'h0, PS_RESET, 1'b0});
    rd(IDX_CLOCK_OPENING);
    chk(d, {25'h0, CS_RESET, 1'b0, WIN_UNLOCKED});
    rd(10'h1a0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(IDX_PSC_HIGH, 8'hff);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(IDX_PSC_HIGH);
    chk(d, 32'h0);
    wr(IDX_EVENT_MASK, 8'h01);
    // each round picks a source and period; the last round takes a reserved code
    for (k = 0; k < 4; k++) begin
      p = (k < 3) ? k : $urandom_range(19, 31);
      cs = k;
      wr(IDX_CLOCK_OPENING, {1'b0, 3'(cs), 4'h7});
      rd(IDX_CLOCK_OPENING);
      chk(d, {25'h0, 3'(cs), 4'h7});
      wr(IDX_PERIOD_ENABLE, {2'b00, 5'(p), 1'b1});
      rd(IDX_PERIOD_ENABLE);
      chk(d, {26'h0, 5'(p), 1'b1});
      tick((cs + 1) % 4, 3);
      rd(IDX_PSC_LOW);
      chk(d, 32'h0);
      tick(cs, ratio(p) - 2);
      chk(n_wdr, k);
      rd(IDX_PSC_LOW);
      chk(d, ratio(p) - 2);
      tick(cs, 3);
      chk(n_wdr, k + 1);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_EVENT_STATUS, 8'h01);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    wr(IDX_EVENT_MASK, 8'h00);
    tick(cs, 33);
    chk({31'h0, irq}, 32'h0);
    rd(IDX_EVENT_STATUS);
    chk(d, 32'h1);
    wr(IDX_EVENT_STATUS, 8'h01);
    clear_wd();
    chk(n_wdr, 5);
    // windowed operation at the shortest period, so position equals the tick count
    w = $urandom_range(0, 6);
    wr(IDX_CLOCK_OPENING, {5'h0, 3'(w)});
    wr(IDX_PERIOD_ENABLE, 8'h01);
    k = $urandom_range(1, opens_at(w) - 1);
    tick(0, k);
    rd(IDX_PERIOD_ENABLE);
    rd(IDX_TIMER_STATUS);
    chk(d, {24'h0, 5'(k), 1'b1, 2'b00});
    clear_wd();
    chk(n_wdr, 6);
    tick(0, opens_at(w));
    rd(IDX_PERIOD_ENABLE);
    clear_wd();
    chk(n_wdr, 6);
    rd(IDX_PSC_LOW);
    chk(d, 32'h0);
    tick(0, 3);
    clear_wd();
    chk(n_wdr, 7);
    rd(IDX_EVENT_STATUS);
    chk(d, 32'h2);
    tick(0, 5);
    wr(IDX_PERIOD_ENABLE, 8'h01);
    rd(IDX_PSC_LOW);
    chk(d, 32'h0);
    // locked configuration, always-on mode, time-out while asleep
    p = $urandom_range(0, 1);
    cs = $urandom_range(0, 3);
    w = $urandom_range(0, 6);
    do_reset(MODE_ALWAYS, 5'(p), 3'(cs), 3'(w));
    rd(IDX_PERIOD_ENABLE);
    chk(d, {26'h0, 5'(p), 1'b0});
    wr(IDX_PERIOD_ENABLE, 8'h24);
    rd(IDX_PERIOD_ENABLE);
    chk(d, {26'h0, 5'(p), 1'b0});
    wr(IDX_CLOCK_OPENING, 8'h77);
    rd(IDX_CLOCK_OPENING);
    chk(d, {25'h0, 3'(cs), 1'b0, 3'(w)});
    @(posedge clk);
    sleep <= 1;
    tick(cs, ratio(p) + 1);
    chk(n_wake, 1);
    chk(n_wdr, 0);
    // mode 00 ignores the software enable
    do_reset(MODE_OFF, PS_MIN, CS_UNLOCKED, WIN_UNLOCKED);
    wr(IDX_PERIOD_ENABLE, 8'h01);
    tick(0, 40);
    chk(n_wdr, 0);
    rd(IDX_PSC_LOW);
    chk(d, 32'h0);
    // mode 10 stops the watchdog while asleep only
    do_reset(MODE_AWAKE, PS_MIN, CS_UNLOCKED, WIN_UNLOCKED);
    sleep <= 1;
    tick(0, 40);
    chk(n_wake + n_wdr, 0);
    sleep <= 0;
    tick(0, 33);
    chk(n_wdr, 1);
    end_of_test();
  end
endmodule : tb_top
